//--- test/sfs_host_model.sv
// SPI host model that frames commands towards the flash block.
`timescale 1ns/1ns
`default_nettype none
module sfs_host_model (
  output logic spiClk,
  output logic chipSelectN,
  output logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutEn
);
  initial begin
    spiClk = 1'b0;
    chipSelectN = 1'b0;
    serialIn = 1'b0;
    #1;
    chipSelectN = 1'b1;
  end
  // Sends nBits of tx most significant first and samples the output before each rising edge.
  task automatic frame(input int nBits, input logic [63:0] tx, output logic [63:0] rx, output logic sawEn);
    rx = 64'h0;
    sawEn = 1'b0;
    chipSelectN = 1'b0;
    #63;
    for (int i = nBits - 1; i >= 0; i--) begin
      serialIn = tx[i];
      #62;
      rx[i] = serialOut;
      sawEn = sawEn | serialOutEn;
      spiClk = 1'b1;
      #63;
      spiClk = 1'b0;
    end
    #62;
    chipSelectN = 1'b1;
    serialIn = ~serialIn;
    #1000;
  endtask : frame
endmodule : sfs_host_model
`default_nettype wire

//--- test/tb_top.sv
// Testbench of the serial flash status and read block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sfs_pkg::*;
  logic clk;
  logic rst;
  logic writeProtectN;
  logic spiClk;
  logic chipSelectN;
  logic serialIn;
  logic serialOut;
  logic serialOutEn;
  logic chipEraseStart;
  sfs_addr_t arrayAddr;
  sfs_byte_t arrayData;
  logic [63:0] rx;
  logic sawEn;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int eraseStarts = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Array contents follow a fixed pattern of the address.
  function automatic sfs_byte_t pat(input sfs_addr_t a);
    return a[7:0] ^ a[15:8] ^ {6'h00, a[17:16]};
  endfunction : pat
  assign arrayData = pat(arrayAddr);

  sfs_flash_status #(.TW_CYCLES(25'h0000028), .CE_CYCLES(25'h0000032)) dut (
    .clk(clk), .rst(rst), .spiClk(spiClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
    .writeProtectN(writeProtectN), .arrayData(arrayData), .arrayAddr(arrayAddr),
    .serialOut(serialOut), .serialOutEn(serialOutEn), .chipEraseStart(chipEraseStart)
  );
  sfs_host_model host (
    .spiClk(spiClk), .chipSelectN(chipSelectN), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutEn(serialOutEn)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Counts erase pulses and cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (chipEraseStart === 1'b1) eraseStarts++;
    if (cycles == 6000) begin
      miscompares++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic cmd(input logic [7:0] op);
    host.frame(8, {56'h0, op}, rx, sawEn);
  endtask : cmd
  task automatic status_is(input sfs_byte_t exp);
    host.frame(16, 64'h0500, rx, sawEn);
    check({16'h0000, rx[7:0]}, {16'h0000, exp});
  endtask : status_is
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      host.frame(16, 64'h0500, rx, sawEn);
      n++;
    end while (rx[0] !== 1'b0 && n < 40);
    check({23'h0, rx[0]}, 24'h000000);
  endtask : wait_idle

  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    host.frame(24, 64'h050000, rx, sawEn);
    check(rx[23:0], 24'h000000);
    check({23'h0, sawEn}, 24'h000001);
    check({22'h0, serialOutEn, serialOut}, 24'h000000);
  endtask : s_reset
  task automatic s_latch();
    cmd(8'h06);
    status_is(8'h02);
    host.frame(9, 64'h04 << 1, rx, sawEn);
    status_is(8'h02);
    cmd(8'h04);
    status_is(8'h00);
  endtask : s_latch
  task automatic s_status_write_cmd();
    host.frame(16, 64'h01FF, rx, sawEn);
    status_is(8'h00);
    cmd(8'h06);
    host.frame(16, 64'h01FF, rx, sawEn);
    host.frame(56, 64'h05 << 48, rx, sawEn);
    check({16'h0, rx[47:40]}, 24'h000003);
    check({16'h0, rx[7:0]}, 24'h00009C);
  endtask : s_status_write_cmd
  task automatic s_protect();
    cmd(8'h06);
    host.frame(17, 64'h0100 << 1, rx, sawEn);
    status_is(8'h9E);
    @(negedge clk);
    writeProtectN = 1'b0;
    repeat (6) @(negedge clk);
    host.frame(16, 64'h0100, rx, sawEn);
    status_is(8'h9E);
    cmd(8'hC7);
    status_is(8'h9E);
    check(24'(eraseStarts), 24'h000000);
    @(negedge clk);
    writeProtectN = 1'b1;
    repeat (6) @(negedge clk);
    host.frame(16, 64'h0100, rx, sawEn);
    wait_idle();
    status_is(8'h00);
  endtask : s_protect
  task automatic s_erase_busy();
    cmd(8'h06);
    cmd(8'h60);
    host.frame(48, 64'h03000000 << 16, rx, sawEn);
    check({23'h0, sawEn}, 24'h000000);
    wait_idle();
    status_is(8'h00);
    check(24'(eraseStarts), 24'h000001);
  endtask : s_erase_busy
  task automatic s_read();
    host.frame(56, 64'h0303FFFE << 24, rx, sawEn);
    check(rx[23:0], {pat(24'h03FFFE), pat(24'h03FFFF), pat(24'h000000)});
    host.frame(45, 64'h03000010 << 13, rx, sawEn);
    check({16'h0, rx[12:5]}, {16'h0, pat(24'h000010)});
    check({22'h0, serialOutEn, serialOut}, 24'h000000);
  endtask : s_read
  task automatic s_secure();
    cmd(8'h3A);
    cmd(8'h06);
    host.frame(16, 64'h0100, rx, sawEn);
    wait_idle();
    status_is(8'h80);
    cmd(8'h04);
    status_is(8'h00);
  endtask : s_secure

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    writeProtectN = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    s_reset();
    s_latch();
    s_status_write_cmd();
    s_protect();
    s_erase_busy();
    s_read();
    s_secure();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

//--- verilog/sfs_consts.svh
// Shared constants of the serial flash status and read block.
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH

`define SFS_OP_WR_ENABLE 8'h06
`define SFS_OP_WR_DISABLE 8'h04
`define SFS_OP_STAT_READ 8'h05
`define SFS_OP_STAT_WRITE 8'h01
`define SFS_OP_READ 8'h03
`define SFS_OP_CE_A 8'hC7
`define SFS_OP_CE_B 8'h60
`define SFS_OP_SECURE 8'h3A
`define SFS_OP_NONE 8'h00

`define SFS_ST_BUSY 0
`define SFS_ST_LATCH 1
`define SFS_ST_BP_LO 2
`define SFS_ST_BP_HI 4
`define SFS_ST_RSV_LO 5
`define SFS_ST_RSV_HI 6
`define SFS_ST_TOP 7
`define SFS_RSV_VALUE 2'h0
`define SFS_BP_NONE 3'h0
`define SFS_BP_RESET 3'h0
`define SFS_BIT_RESET 1'h0

`define SFS_ADDR_W 24
`define SFS_ADDR_MASK 24'h03FFFF
`define SFS_ADDR_ZERO 24'h000000
`define SFS_ADDR_ONE 24'h000001
`define SFS_BIT_FIRST 3'h0
`define SFS_BIT_LAST 3'h7
`define SFS_BYTES_MAX 3'h7
`define SFS_BYTES_ZERO 3'h0
`define SFS_BYTES_ONE 3'h1
`define SFS_BYTES_TWO 3'h2
`define SFS_BYTES_ADDR_END 3'h3
`define SFS_BYTES_DATA 3'h4

`define SFS_CLK_MHZ 10
`define SFS_TW_US 10000
`define SFS_TCE_MS 3000
`define SFS_CNT_W 25
`define SFS_CNT_ZERO 25'h0000000
`define SFS_CNT_ONE 25'h0000001

`endif

//--- verilog/sfs_flash_status.sv
// Status register, protection and array read command logic of a serial flash.
`timescale 1ns/1ns
`default_nettype none
`include "sfs_consts.svh"

module sfs_flash_status #(
  parameter logic [`SFS_CNT_W-1:0] TW_CYCLES = `SFS_CNT_W'(`SFS_TW_US * `SFS_CLK_MHZ),
  parameter logic [`SFS_CNT_W-1:0] CE_CYCLES = `SFS_CNT_W'(`SFS_TCE_MS * 1000 * `SFS_CLK_MHZ)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic spiClk,
  input wire logic chipSelectN,
  input wire logic serialIn,
  input wire logic writeProtectN,
  input wire sfs_pkg::sfs_byte_t arrayData,
  output sfs_pkg::sfs_addr_t arrayAddr,
  output logic serialOut,
  output logic serialOutEn,
  output logic chipEraseStart
);
  import sfs_pkg::*;

  function automatic logic frameOk(input logic [2:0] bytes, input logic aligned, input logic [2:0] want);
    frameOk = aligned && (bytes == want);
  endfunction : frameOk

  function automatic sfs_addr_t nextAddr(input sfs_addr_t a);
    nextAddr = (a + `SFS_ADDR_ONE) & `SFS_ADDR_MASK;
  endfunction : nextAddr

  function automatic logic [2:0] nextBytes(input logic [2:0] b);
    nextBytes = (b == `SFS_BYTES_MAX) ? b : b + `SFS_BYTES_ONE;
  endfunction : nextBytes

  ////////////////////////////////////////////////////////////////////////////
  // Link side: shift logic running on the serial clock.

  logic [2:0] bitInByte;
  logic [2:0] byteCnt;
  logic [7:0] shiftIn;
  logic [7:0] opcode;
  logic [15:0] addrHi;
  logic readOk;
  logic [7:0] frameOp;
  logic [7:0] frameData;
  logic [2:0] frameBytes;
  logic frameAligned;
  sfs_byte_t statMeta;
  sfs_byte_t statLink;
  sfs_byte_t statusByte;
  sfs_byte_t outByte;
  logic [7:0] next_shift;
  logic byteDone;
  logic dataPhase;
  sfs_byte_t outSrc;

  assign next_shift = {shiftIn[6:0], serialIn};
  assign byteDone = (bitInByte == `SFS_BIT_LAST);

  always_ff @(posedge spiClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      bitInByte <= `SFS_BIT_FIRST;
      byteCnt <= `SFS_BYTES_ZERO;
      shiftIn <= `SFS_OP_NONE;
    end else begin
      bitInByte <= bitInByte + `SFS_BYTES_ONE;
      shiftIn <= next_shift;
      if (byteDone) begin
        byteCnt <= nextBytes(byteCnt);
      end
    end
  end

  always_ff @(posedge spiClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      opcode <= `SFS_OP_NONE;
      addrHi <= 16'h0000;
      readOk <= 1'b0;
      arrayAddr <= `SFS_ADDR_ZERO;
    end else if (byteDone) begin
      unique case (byteCnt)
        `SFS_BYTES_ZERO: begin
          opcode <= next_shift;
          readOk <= !statLink[`SFS_ST_BUSY];
        end
        `SFS_BYTES_ONE, `SFS_BYTES_TWO: begin
          addrHi <= {addrHi[7:0], next_shift};
        end
        `SFS_BYTES_ADDR_END: begin
          arrayAddr <= {addrHi, next_shift} & `SFS_ADDR_MASK;
        end
        default: begin
          arrayAddr <= nextAddr(arrayAddr);
        end
      endcase
    end
  end

  // Frame summary survives the select edge so the core can judge the command.
  always_ff @(posedge spiClk) begin
    frameAligned <= byteDone;
    if (bitInByte == `SFS_BIT_FIRST && byteCnt == `SFS_BYTES_ZERO) begin
      frameOp <= `SFS_OP_NONE;
      frameBytes <= `SFS_BYTES_ZERO;
    end else if (byteDone) begin
      frameBytes <= nextBytes(byteCnt);
      if (byteCnt == `SFS_BYTES_ZERO) begin
        frameOp <= next_shift;
      end
      if (byteCnt == `SFS_BYTES_ONE) begin
        frameData <= next_shift;
      end
    end
  end

  // Status byte crossing into the serial clock domain; a copy is taken only when two late stages agree.
  sfs_byte_t statMid;
  sfs_byte_t statLate;
  always_ff @(posedge spiClk) begin
    statMeta <= statusByte;
    statMid <= statMeta;
    statLate <= statMid;
    if (statMid == statLate) begin
      statLink <= statLate;
    end
  end

  assign dataPhase = (byteCnt != `SFS_BYTES_ZERO) &&
                     ((opcode == `SFS_OP_STAT_READ) ||
                      (opcode == `SFS_OP_READ && readOk && byteCnt >= `SFS_BYTES_DATA));
  assign outSrc = (opcode == `SFS_OP_STAT_READ) ? statLink : arrayData;

  always_ff @(negedge spiClk or posedge chipSelectN) begin
    if (chipSelectN) begin
      outByte <= `SFS_OP_NONE;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
    end else if (dataPhase) begin
      serialOutEn <= 1'b1;
      if (bitInByte == `SFS_BIT_FIRST) begin
        outByte <= outSrc;
        serialOut <= outSrc[`SFS_ST_TOP];
      end else begin
        serialOut <= outByte[~bitInByte];
      end
    end else begin
      serialOutEn <= 1'b0;
      serialOut <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core side: pin synchronisers.

  logic csA;
  logic csB;
  logic csC;
  logic csLvl;
  logic wpA;
  logic wpB;
  logic wpC;
  logic wpLvl;
  logic csRise;

  always_ff @(posedge clk) begin
    if (rst) begin
      {csA, csB, csC, csLvl} <= 4'hF;
      {wpA, wpB, wpC, wpLvl} <= 4'hF;
    end else begin
      csA <= chipSelectN;
      csB <= csA;
      csC <= csB;
      if (csB == csC) begin
        csLvl <= csC;
      end
      wpA <= writeProtectN;
      wpB <= wpA;
      wpC <= wpB;
      if (wpB == wpC) begin
        wpLvl <= wpC;
      end
    end
  end

  assign csRise = !csLvl && csB && csC;

  ////////////////////////////////////////////////////////////////////////////
  // Core side: command execution at the end of a frame.

  sfs_state_t state;
  logic [`SFS_CNT_W-1:0] busyCnt;
  logic enLatch;
  logic secureMode;
  logic secureLock;
  logic [2:0] blockProt;
  logic statusProt;
  logic [7:0] wrData;
  logic hwLock;
  logic idle;
  logic cmdEnable;
  logic cmdDisable;
  logic cmdSecure;
  logic cmdStatWrite;
  logic cmdCe;
  logic cycleDone;
  logic statWriteDone;

  assign idle = (state == SFS_IDLE);
  assign hwLock = statusProt && !wpLvl;
  assign cmdEnable = csRise && idle && frameOp == `SFS_OP_WR_ENABLE &&
                     frameOk(frameBytes, frameAligned, `SFS_BYTES_ONE);
  assign cmdDisable = csRise && idle && frameOp == `SFS_OP_WR_DISABLE &&
                      frameOk(frameBytes, frameAligned, `SFS_BYTES_ONE);
  assign cmdSecure = csRise && idle && frameOp == `SFS_OP_SECURE &&
                     frameOk(frameBytes, frameAligned, `SFS_BYTES_ONE);
  assign cmdStatWrite = csRise && idle && enLatch && !hwLock && frameOp == `SFS_OP_STAT_WRITE &&
                        frameOk(frameBytes, frameAligned, `SFS_BYTES_TWO);
  assign cmdCe = csRise && idle && enLatch && blockProt == `SFS_BP_NONE &&
                 (frameOp == `SFS_OP_CE_A || frameOp == `SFS_OP_CE_B) &&
                 frameOk(frameBytes, frameAligned, `SFS_BYTES_ONE);
  assign cycleDone = !idle && busyCnt == `SFS_CNT_ONE;
  assign statWriteDone = cycleDone && state == SFS_STATUS_BUSY;

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SFS_IDLE;
      busyCnt <= `SFS_CNT_ZERO;
      chipEraseStart <= 1'b0;
    end else begin
      chipEraseStart <= cmdCe;
      unique case (state)
        SFS_IDLE: begin
          if (cmdStatWrite) begin
            state <= SFS_STATUS_BUSY;
            busyCnt <= TW_CYCLES;
          end else if (cmdCe) begin
            state <= SFS_ERASE_BUSY;
            busyCnt <= CE_CYCLES;
          end
        end
        SFS_STATUS_BUSY, SFS_ERASE_BUSY: begin
          busyCnt <= busyCnt - `SFS_CNT_ONE;
          if (cycleDone) begin
            state <= SFS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enLatch <= `SFS_BIT_RESET;
    end else if (cycleDone) begin
      enLatch <= 1'b0;
    end else if (cmdEnable) begin
      enLatch <= 1'b1;
    end else if (cmdDisable && !secureMode) begin
      enLatch <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      secureMode <= 1'b0;
    end else if (cmdSecure) begin
      secureMode <= 1'b1;
    end else if (cmdDisable && secureMode) begin
      secureMode <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrData <= `SFS_OP_NONE;
    end else if (cmdStatWrite) begin
      wrData <= frameData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      blockProt <= `SFS_BP_RESET;
      statusProt <= `SFS_BIT_RESET;
      secureLock <= `SFS_BIT_RESET;
    end else if (statWriteDone) begin
      if (secureMode) begin
        secureLock <= 1'b1;
      end else begin
        blockProt <= wrData[`SFS_ST_BP_HI:`SFS_ST_BP_LO];
        statusProt <= wrData[`SFS_ST_TOP];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      statusByte <= `SFS_OP_NONE;
    end else begin
      statusByte <= {secureMode ? secureLock : statusProt,
                     `SFS_RSV_VALUE,
                     blockProt,
                     enLatch,
                     !idle};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_busy_tracks_state: assert property (@(posedge clk) disable iff (rst)
    ##1 statusByte[`SFS_ST_BUSY] == !$past(idle))
    else $error("Busy bit does not follow the write cycle.");

  chk_latch_done_clear: assert property (@(posedge clk) disable iff (rst)
    cycleDone |=> !enLatch ##1 !statusByte[`SFS_ST_LATCH])
    else $error("Enable latch not cleared after cycle.");

  chk_write_needs_latch: assert property (@(posedge clk) disable iff (rst)
    (csRise && idle && !enLatch) |=> state == SFS_IDLE)
    else $error("Write cycle started without enable latch.");

  chk_hw_lock_refuse: assert property (@(posedge clk) disable iff (rst)
    (csRise && idle && hwLock && frameOp == `SFS_OP_STAT_WRITE) |=> state == SFS_IDLE)
    else $error("Status write accepted under hardware lock.");

  chk_ce_protect: assert property (@(posedge clk) disable iff (rst)
    (csRise && blockProt != `SFS_BP_NONE) |=> !chipEraseStart && state != SFS_ERASE_BUSY)
    else $error("Chip erase ran with block protection set.");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    statusByte[`SFS_ST_RSV_HI:`SFS_ST_RSV_LO] == `SFS_RSV_VALUE)
    else $error("Reserved status bits not zero.");

  chk_write_updates: assert property (@(posedge clk) disable iff (rst)
    (statWriteDone && !secureMode) |=> blockProt == $past(wrData[`SFS_ST_BP_HI:`SFS_ST_BP_LO]) && !enLatch)
    else $error("Status write did not update protection bits.");

  chk_secure_exit: assert property (@(posedge clk) disable iff (rst)
    (cmdDisable && secureMode) |=> !secureMode && enLatch == $past(enLatch))
    else $error("Write disable in secure mode touched the latch.");

  chk_busy_holds: assert property (@(posedge clk) disable iff (rst)
    cmdStatWrite |=> (state == SFS_STATUS_BUSY) [*8])
    else $error("Status write cycle ended too early.");

  chk_secure_lock_once: assert property (@(posedge clk) disable iff (rst)
    (statWriteDone && secureMode) |=> secureLock && $stable(blockProt))
    else $error("Secure status write did not set the lock.");

endmodule : sfs_flash_status
`default_nettype wire

//--- verilog/sfs_pkg.sv
// Types of the serial flash status and read block.
`default_nettype none
package sfs_pkg;
  `include "sfs_consts.svh"
  typedef logic [7:0] sfs_byte_t;
  typedef logic [`SFS_ADDR_W-1:0] sfs_addr_t;
  typedef enum logic [2:0] {
    SFS_IDLE = 3'b001,
    SFS_STATUS_BUSY = 3'b010,
    SFS_ERASE_BUSY = 3'b100
  } sfs_state_t;
endpackage : sfs_pkg
`default_nettype wire
